// ### inc/slp_pkg.sv
// Function
// - length byte first, then checksum, payload
// - checksum sums payload bytes only
// - payload is length minus two bytes
// - answer 0xCC good, 0x33 bad
// - ack means packet ok, not command
// - device may pad zeros before length
// - returned packet bytes sent without gaps
// - device ignores zeros before host answer
// - first payload byte is command code
// - ping 0x20, three bytes, status success
// - status query 0x23 returns one byte
// - download 0x21, address, count, msb first
// - download erases area before ack
// - data write 0x24, up to eight bytes
// - programming ends at download byte count
// - nak leaves program address unchanged
// - run 0x22, seven bytes, ack first
// - reset 0x25, ack then software reset
package slp_pkg;
    localparam logic [7:0] SLP_ACK          = 8'hCC;
    localparam logic [7:0] SLP_NAK          = 8'h33;
    localparam logic [7:0] SLP_CMD_PING     = 8'h20;
    localparam logic [7:0] SLP_CMD_DOWNLOAD = 8'h21;
    localparam logic [7:0] SLP_CMD_RUN      = 8'h22;
    localparam logic [7:0] SLP_CMD_QUERY    = 8'h23;
    localparam logic [7:0] SLP_CMD_WRITE    = 8'h24;
    localparam logic [7:0] SLP_CMD_RESET    = 8'h25;
    localparam logic [7:0] SLP_LEN_SHORT    = 8'h03;
    localparam logic [7:0] SLP_LEN_RUN      = 8'h07;
    localparam logic [7:0] SLP_LEN_LONG     = 8'h0B;
    localparam logic [7:0] SLP_LEN_MIN_WR   = 8'h04;
    localparam logic [7:0] SLP_HDR_BYTES    = 8'h02;
    // status codes: values are arbitrary
    localparam logic [7:0] SLP_ST_SUCCESS   = 8'h40;
    localparam logic [7:0] SLP_ST_UNKNOWN   = 8'h41;
    localparam logic [7:0] SLP_ST_INVALID   = 8'h42;
    localparam logic [7:0] SLP_ST_FLASHFAIL = 8'h43;
    localparam logic [7:0] SLP_ST_RESET     = SLP_ST_SUCCESS;
    localparam logic [3:0] SLP_BUF_BYTES    = 4'h9;
    localparam logic [1:0] SLP_RSP_LAST     = 2'h2;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_SUM   = 4'h1,
        S_BODY  = 4'h2,
        S_CHECK = 4'h3,
        S_FLASH = 4'h4,
        S_ACK   = 4'h5,
        S_EXEC  = 4'h6,
        S_RSP   = 4'h7,
        S_WAIT  = 4'h8
    } slp_state_t;

    // one flash operation: erase of a range or program of up to 8 bytes
    typedef struct packed {
        logic        erase;
        logic [31:0] addr;
        logic [31:0] count;
        logic [63:0] data;
    } slp_flash_req_t;
endpackage

// ### hw/slp_sum.sv
`timescale 1ns/100ps
// running byte sum, wraps at the accumulator width
module slp_sum #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         clear,
    input  wire logic         add,
    input  wire logic [W-1:0] data,
    output logic      [W-1:0] sum
);
    logic [W-1:0] sum_q;
    logic [W-1:0] sum_d;

    // carry out is dropped on purpose
    assign sum_d = sum_q + data;
    assign sum   = sum_q;

    // clear wins so a new packet never inherits the old sum
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            sum_q <= '0;
        end else if (add) begin
            sum_q <= sum_d;
        end
    end
endmodule

// ### hw/slp_loader.sv
`timescale 1ns/100ps
// packet framing and command interpreter of the serial loader
module slp_loader (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    rxValid,
    input  wire logic [7:0]              rxData,
    input  wire logic                    txReady,
    output logic                         txValid,
    output logic      [7:0]              txData,
    output logic                         flashReqValid,
    output slp_pkg::slp_flash_req_t      flashReq,
    input  wire logic                    flashDone,
    input  wire logic                    flashError,
    output logic                         runValid,
    output logic      [31:0]             runAddr,
    output logic                         swResetReq,
    output logic                         sessionActive,
    output logic      [7:0]              lastStatus
);
    import slp_pkg::*;

    slp_state_t     state_q, state_d;
    logic [7:0]     len_q, len_d;
    logic [7:0]     csum_q, csum_d;
    logic [7:0]     left_q, left_d;
    logic [3:0]     idx_q, idx_d;
    logic [7:0]     buf_q [0:8];
    logic [7:0]     status_q, status_d;
    logic [31:0]    progAddr_q, progAddr_d;
    logic [31:0]    progLeft_q, progLeft_d;
    logic           session_q, session_d;
    logic           execAfter_q, execAfter_d;
    logic           txValid_q, txValid_d;
    logic [7:0]     txData_q, txData_d;
    logic           flashValid_q, flashValid_d;
    slp_flash_req_t flashReq_q, flashReq_d;
    logic           runValid_q, runValid_d;
    logic [31:0]    runAddr_q, runAddr_d;
    logic           swReset_q, swReset_d;

    logic           rxNonZero;
    logic           sumClear;
    logic           sumAdd;
    logic           storeEn;
    logic [7:0]     sumVal;
    logic           sumOk;
    logic           txDone;
    logic [7:0]     cmd;
    logic [31:0]    paramA;
    logic [31:0]    paramB;
    logic [63:0]    wrData;
    logic [31:0]    dataBytes;
    logic [31:0]    progCount;
    logic           isDownload;

    // zero bytes are padding and never start or answer anything
    assign rxNonZero = rxValid && (rxData != 8'h00);
    assign sumClear  = (state_q == S_IDLE) && rxNonZero;
    assign sumAdd    = (state_q == S_BODY) && rxValid;
    assign storeEn   = sumAdd && (idx_q < SLP_BUF_BYTES);
    assign txDone    = txValid_q && txReady;

    // a length below three cannot hold a command
    assign sumOk = (sumVal == csum_q) && (len_q >= SLP_LEN_SHORT);

    // parameters are big endian after the command byte
    assign cmd    = buf_q[0];
    assign paramA = {buf_q[1], buf_q[2], buf_q[3], buf_q[4]};
    assign paramB = {buf_q[5], buf_q[6], buf_q[7], buf_q[8]};
    assign wrData = {paramA, paramB};
    assign isDownload = (cmd == SLP_CMD_DOWNLOAD) && (len_q == SLP_LEN_LONG);

    // bytes to program: data in packet, capped by what is still owed
    assign dataBytes = {24'h000000, len_q - SLP_LEN_SHORT};
    assign progCount = (dataBytes < progLeft_q) ? dataBytes
                                                : progLeft_q;

    slp_sum #(
        .W(8)
    ) uSum (
        .clk  (clk),
        .reset(reset),
        .clear(sumClear),
        .add  (sumAdd),
        .data (rxData),
        .sum  (sumVal)
    );

    // next state and next register values
    always_comb begin
        state_d      = state_q;
        len_d        = len_q;
        csum_d       = csum_q;
        left_d       = left_q;
        idx_d        = idx_q;
        status_d     = status_q;
        progAddr_d   = progAddr_q;
        progLeft_d   = progLeft_q;
        session_d    = session_q;
        execAfter_d  = execAfter_q;
        txValid_d    = txValid_q;
        txData_d     = txData_q;
        flashValid_d = 1'b0;
        flashReq_d   = flashReq_q;
        runValid_d   = 1'b0;
        runAddr_d    = runAddr_q;
        swReset_d    = 1'b0;
        if (txDone) begin
            txValid_d = 1'b0;
        end
        case (state_q)
            S_IDLE: begin
                // first nonzero byte is the total length
                if (rxNonZero) begin
                    len_d   = rxData;
                    idx_d   = 4'h0;
                    state_d = (rxData < SLP_HDR_BYTES) ? S_CHECK : S_SUM;
                end
            end
            S_SUM: begin
                if (rxValid) begin
                    csum_d  = rxData;
                    left_d  = len_q - SLP_HDR_BYTES;
                    state_d = (len_q == SLP_HDR_BYTES) ? S_CHECK : S_BODY;
                end
            end
            S_BODY: begin
                // long packets are summed in full, extra bytes not kept
                if (rxValid) begin
                    left_d = left_q - 8'h01;
                    if (idx_q < SLP_BUF_BYTES) begin
                        idx_d = idx_q + 4'h1;
                    end
                    if (left_q == 8'h01) begin
                        state_d = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                if (!sumOk) begin
                    // nothing runs for a damaged packet
                    txValid_d   = 1'b1;
                    txData_d    = SLP_NAK;
                    execAfter_d = 1'b0;
                    state_d     = S_ACK;
                end else if (isDownload) begin
                    // erase first; the ack waits until it is over
                    flashValid_d     = 1'b1;
                    flashReq_d.erase = 1'b1;
                    flashReq_d.addr  = paramA;
                    flashReq_d.count = paramB;
                    flashReq_d.data  = 64'h0;
                    state_d          = S_FLASH;
                end else begin
                    txValid_d   = 1'b1;
                    txData_d    = SLP_ACK;
                    execAfter_d = 1'b1;
                    state_d     = S_ACK;
                end
            end
            S_FLASH: begin
                if (flashDone) begin
                    status_d = flashError ? SLP_ST_FLASHFAIL
                                          : SLP_ST_SUCCESS;
                    if (flashReq_q.erase) begin
                        // new session starts at the erased range
                        progAddr_d  = flashReq_q.addr;
                        progLeft_d  = flashReq_q.count;
                        session_d   = !flashError
                                      && (flashReq_q.count != 32'h0);
                        txValid_d   = 1'b1;
                        txData_d    = SLP_ACK;
                        execAfter_d = 1'b0;
                        state_d     = S_ACK;
                    end else begin
                        // advance only after an accepted write
                        progAddr_d = progAddr_q
                                     + flashReq_q.count;
                        progLeft_d = progLeft_q - flashReq_q.count;
                        session_d  = !flashError
                                     && (progLeft_q
                                         != flashReq_q.count);
                        state_d    = S_IDLE;
                    end
                end
            end
            S_ACK: begin
                if (txDone) begin
                    state_d = execAfter_q ? S_EXEC : S_IDLE;
                end
            end
            S_EXEC: begin
                state_d  = S_IDLE;
                status_d = SLP_ST_INVALID;
                case (cmd)
                    SLP_CMD_PING: begin
                        if (len_q == SLP_LEN_SHORT) begin
                            status_d = SLP_ST_SUCCESS;
                        end
                    end
                    SLP_CMD_QUERY: begin
                        status_d = status_q;
                        if (len_q == SLP_LEN_SHORT) begin
                            // answer packet: length, sum, status
                            txValid_d = 1'b1;
                            txData_d  = SLP_LEN_SHORT;
                            idx_d     = 4'h0;
                            state_d   = S_RSP;
                        end else begin
                            status_d = SLP_ST_INVALID;
                        end
                    end
                    SLP_CMD_WRITE: begin
                        // a write outside a download session is refused
                        if (session_q && (len_q >= SLP_LEN_MIN_WR)
                            && (len_q <= SLP_LEN_LONG)) begin
                            flashValid_d     = 1'b1;
                            flashReq_d.erase = 1'b0;
                            flashReq_d.addr  = progAddr_q;
                            flashReq_d.count = progCount;
                            flashReq_d.data  = wrData;
                            state_d          = S_FLASH;
                        end
                    end
                    SLP_CMD_RUN: begin
                        if (len_q == SLP_LEN_RUN) begin
                            runValid_d = 1'b1;
                            runAddr_d  = paramA;
                            status_d   = SLP_ST_SUCCESS;
                        end
                    end
                    SLP_CMD_RESET: begin
                        if (len_q == SLP_LEN_SHORT) begin
                            swReset_d = 1'b1;
                            status_d  = SLP_ST_SUCCESS;
                        end
                    end
                    default: begin
                        status_d = SLP_ST_UNKNOWN;
                    end
                endcase
            end
            S_RSP: begin
                // next byte loads as the last is taken: no gaps
                if (txDone) begin
                    if (idx_q[1:0] == SLP_RSP_LAST) begin
                        state_d = S_WAIT;
                    end else begin
                        txValid_d = 1'b1;
                        txData_d  = status_q;
                        idx_d     = idx_q + 4'h1;
                    end
                end
            end
            S_WAIT: begin
                // host answer; a nak is followed by a resent query
                if (rxNonZero) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // payload buffer, command byte at index zero
    always_ff @(posedge clk) begin
        if (storeEn) begin
            buf_q[idx_q] <= rxData;
        end
    end

    // control registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q     <= S_IDLE;
            len_q       <= 8'h00;
            csum_q      <= 8'h00;
            left_q      <= 8'h00;
            idx_q       <= 4'h0;
            status_q    <= SLP_ST_RESET;
            progAddr_q  <= 32'h00000000;
            progLeft_q  <= 32'h00000000;
            session_q   <= 1'b0;
            execAfter_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            len_q       <= len_d;
            csum_q      <= csum_d;
            left_q      <= left_d;
            idx_q       <= idx_d;
            status_q    <= status_d;
            progAddr_q  <= progAddr_d;
            progLeft_q  <= progLeft_d;
            session_q   <= session_d;
            execAfter_q <= execAfter_d;
        end
    end

    // output registers
    always_ff @(posedge clk) begin
        if (reset) begin
            txValid_q    <= 1'b0;
            txData_q     <= 8'h00;
            flashValid_q <= 1'b0;
            flashReq_q   <= '0;
            runValid_q   <= 1'b0;
            runAddr_q    <= 32'h00000000;
            swReset_q    <= 1'b0;
        end else begin
            txValid_q    <= txValid_d;
            txData_q     <= txData_d;
            flashValid_q <= flashValid_d;
            flashReq_q   <= flashReq_d;
            runValid_q   <= runValid_d;
            runAddr_q    <= runAddr_d;
            swReset_q    <= swReset_d;
        end
    end

    assign txValid       = txValid_q;
    assign txData        = txData_q;
    assign flashReqValid = flashValid_q;
    assign flashReq      = flashReq_q;
    assign runValid      = runValid_q;
    assign runAddr       = runAddr_q;
    assign swResetReq    = swReset_q;
    assign sessionActive = session_q;
    assign lastStatus    = status_q;
endmodule

// ### tb/slp_loader_properties.sv
`timescale 1ns/100ps
// protocol checks on the loader's ports
module slp_loader_properties import slp_pkg::*; (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 txReady,
    input wire logic                 txValid,
    input wire logic           [7:0] txData,
    input wire logic                 flashReqValid,
    input wire slp_pkg::slp_flash_req_t flashReq,
    input wire logic                 flashDone,
    input wire logic                 flashError,
    input wire logic                 runValid,
    input wire logic                 swResetReq,
    input wire logic                 sessionActive,
    input wire logic           [7:0] lastStatus
);
    logic ackTake;
    logic ack1_q;
    logic ack2_q;
    logic erasePend_q;
    assign ackTake = txValid && txReady && txData == SLP_ACK;
    // delayed copies of a taken ack; jumps may only follow one
    always_ff @(posedge clk) begin
        if (reset) begin
            ack1_q      <= 1'b0;
            ack2_q      <= 1'b0;
            erasePend_q <= 1'b0;
        end else begin
            ack1_q      <= ackTake;
            ack2_q      <= ack1_q;
            erasePend_q <= (flashReqValid && flashReq.erase) ||
                           (erasePend_q && !flashDone);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_tx_hold: assert property (txValid && !txReady |=>
        txValid && $stable(txData)) else $error("tx byte not held");
    a_no_padding: assert property (txValid |->
        txData != 8'h00) else $error("zero byte sent");
    a_erase_quiet: assert property (erasePend_q |->
        !txValid) else $error("answer before erase done");
    a_erase_ack: assert property (erasePend_q && flashDone |=>
        txValid && txData == SLP_ACK) else $error("no ack after erase");
    a_fail_status: assert property (flashDone && flashError |=>
        lastStatus == SLP_ST_FLASHFAIL) else $error("fail not recorded");
    a_write_size: assert property (flashReqValid
        && !flashReq.erase |-> flashReq.count inside {[1:8]}
        && sessionActive) else $error("bad program request");
    a_no_gap: assert property (txValid && txReady
        && txData == SLP_LEN_SHORT |=> txValid)
        else $error("gap inside returned packet");
    a_session_end: assert property ($fell(sessionActive) |->
        $past(flashDone)) else $error("session ended without flash op");
    a_run_order: assert property (runValid |->
        ack1_q || ack2_q) else $error("run without ack");
    a_reset_order: assert property (swResetReq |->
        ack1_q || ack2_q) else $error("reset without ack");

    c_ack: cover property (ackTake);
    c_nak: cover property (txValid && txReady && txData == SLP_NAK);
    c_run: cover property (runValid);
    c_erase_fail: cover property (erasePend_q && flashDone && flashError);
endmodule

bind slp_loader slp_loader_properties u_props (.clk(clk), .reset(reset),
    .txReady(txReady), .txValid(txValid), .txData(txData),
    .flashReqValid(flashReqValid), .flashReq(flashReq),
    .flashDone(flashDone), .flashError(flashError), .runValid(runValid),
    .swResetReq(swResetReq), .sessionActive(sessionActive),
    .lastStatus(lastStatus));

// ### tb/slp_host_model.sv
`timescale 1ns/100ps
// host end of the byte link: takes device bytes, prompt or slow
module slp_host_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       stall,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    output logic            txReady,
    output logic            gotValid,
    output logic      [7:0] gotData
);
    logic [2:0] tick = 3'h0;
    // slow mode takes one byte in five cycles
    always @(negedge clk) begin
        tick <= (tick == 3'h4) ? 3'h0 : tick + 3'h1;
        txReady <= !stall || tick == 3'h0;
    end
    // zero padding is skipped, first nonzero byte counts
    always @(posedge clk) begin
        gotValid <= !reset && txValid && txReady
                    && txData != 8'h00;
        gotData  <= txData;
    end
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
// loader bench: host packets in, answers and flash traffic checked
module tb;
    import slp_pkg::*;
    logic           clk = 1'b0;
    logic           reset = 1'b1;
    logic           rxValid = 1'b0;
    logic     [7:0] rxData = 8'h00;
    logic           flashDone = 1'b0;
    logic           flashError = 1'b0;
    logic           stall = 1'b0;
    logic           failNext = 1'b0;
    logic           flashBusy = 1'b0;
    logic           txReady, txValid, gotValid, flashReqValid;
    logic           runValid, swResetReq, sessionActive;
    logic     [7:0] txData, gotData, lastStatus;
    logic    [31:0] runAddr, base, addr;
    logic    [63:0] dat;
    slp_flash_req_t flashReq, fe;
    logic     [7:0] pkt[$], expTx[$];
    slp_flash_req_t expFl[$];
    logic    [32:0] expRun[$];
    int             miscompares = 0;
    int             checked = 0;
    int             seed = 52;

    always #12.5 clk = ~clk;

    slp_loader u_dut (.clk(clk), .reset(reset), .rxValid(rxValid),
        .rxData(rxData), .txReady(txReady), .txValid(txValid),
        .txData(txData), .flashReqValid(flashReqValid), .flashReq(flashReq),
        .flashDone(flashDone), .flashError(flashError), .runValid(runValid),
        .runAddr(runAddr), .swResetReq(swResetReq),
        .sessionActive(sessionActive), .lastStatus(lastStatus));
    slp_host_model u_host (.clk(clk), .reset(reset), .stall(stall),
        .txValid(txValid), .txData(txData), .txReady(txReady),
        .gotValid(gotValid), .gotData(gotData));

    task automatic check(string what, logic [128:0] seen, logic [128:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // bytes go back to back; the lane toggles once released
    task automatic rx(logic [7:0] b);
        @(negedge clk);
        rxValid = 1'b1;
        rxData = b;
    endtask
    task automatic idle();
        @(negedge clk);
        rxValid = 1'b0;
        rxData = ~rxData;
    endtask
    function automatic void w32(logic [31:0] v);
        for (int i = 3; i >= 0; i--) pkt.push_back(v[i*8 +: 8]);
    endfunction

    // frame pkt, note the answers, wait until they and flash are done
    task automatic send(bit bad, logic [7:0] ack, logic [7:0] st);
        logic [7:0] sum;
        int n;
        sum = 8'h00;
        n = 0;
        foreach (pkt[i]) sum += pkt[i];
        expTx.push_back(ack);
        if (st != 8'h00) expTx = {expTx, 8'h03, st, st};
        rx(8'h00);
        rx(8'(pkt.size() + 2));
        rx(bad ? ~sum : sum);
        foreach (pkt[i]) rx(pkt[i]);
        idle();
        while (expTx.size() != 0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        while (flashBusy && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) check("answer wait", 1'b1, 1'b0);
    endtask

    // status query; a host refusal makes it ask again
    task automatic query(logic [7:0] st, bit nakFirst);
        pkt = '{SLP_CMD_QUERY};
        send(1'b0, SLP_ACK, st);
        rx(8'h00);
        rx(nakFirst ? SLP_NAK : SLP_ACK);
        idle();
        repeat (3) @(negedge clk);
        if (nakFirst) query(st, 1'b0);
    endtask

    // flash stand-in with random latency; erase carries no data
    always @(posedge clk) begin
        if (flashReqValid === 1'b1) begin
            fe = expFl.pop_front();
            if (fe.erase) fe.data = flashReq.data;
            check("flashReq", flashReq, fe);
            flashBusy <= 1'b1;
            repeat (2 + ($random(seed) & 7)) @(negedge clk);
            flashError = failNext;
            flashDone = 1'b1;
            @(negedge clk);
            flashDone = 1'b0;
            flashError = 1'b0;
            flashBusy <= 1'b0;
        end
    end

    // output watcher takes the oldest note for each byte or jump
    always @(posedge clk) begin
        if (gotValid === 1'b1)
            check("txData", gotData, expTx.pop_front());
        if (runValid === 1'b1 || swResetReq === 1'b1)
            check("run", {swResetReq,runAddr}, expRun.pop_front());
    end

    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        check("status", lastStatus, SLP_ST_RESET);
        pkt = '{SLP_CMD_PING};
        send(1'b0, SLP_ACK, 8'h00);
        check("status", lastStatus, SLP_ST_SUCCESS);
        pkt = '{8'h26};
        send(1'b0, SLP_ACK, 8'h00);
        query(SLP_ST_UNKNOWN, 1'b1);
        stall = 1'b1;
        pkt = '{SLP_CMD_PING};
        send(1'b1, SLP_NAK, 8'h00);
        query(SLP_ST_UNKNOWN, 1'b0);
        // no payload at all, then a ping of the wrong length
        pkt = {};
        send(1'b0, SLP_NAK, 8'h00);
        pkt = '{SLP_CMD_PING, 8'h01};
        send(1'b0, SLP_ACK, 8'h00);
        query(SLP_ST_INVALID, 1'b0);
        base = $random(seed);
        pkt = '{SLP_CMD_DOWNLOAD};
        w32(base);
        w32(32'h0000000A);
        expFl.push_back(slp_flash_req_t'{1'b1, base, 32'h0000000A, 64'h0});
        send(1'b0, SLP_ACK, 8'h00);
        // ten bytes as eight plus two, a refused packet in between
        for (int k = 0; k < 3; k++) begin
            dat = {$random(seed), $random(seed)};
            pkt = '{SLP_CMD_WRITE};
            for (int i = 7; i >= 0; i--) pkt.push_back(dat[i*8 +: 8]);
            if (k != 1) expFl.push_back(slp_flash_req_t'{1'b0,
                base + 32'(k * 4), 32'(8 - 3 * k), dat});
            send(k == 1, (k == 1) ? SLP_NAK : SLP_ACK, 8'h00);
        end
        check("session", sessionActive, 1'b0);
        send(1'b0, SLP_ACK, 8'h00);
        query(SLP_ST_INVALID, 1'b0);
        failNext = 1'b1;
        pkt = '{SLP_CMD_DOWNLOAD};
        w32(base);
        w32(32'h00000010);
        expFl.push_back(slp_flash_req_t'{1'b1, base, 32'h00000010, 64'h0});
        send(1'b0, SLP_ACK, 8'h00);
        failNext = 1'b0;
        query(SLP_ST_FLASHFAIL, 1'b0);
        addr = $random(seed);
        pkt = '{SLP_CMD_RUN};
        w32(addr);
        expRun.push_back({1'b0, addr});
        send(1'b0, SLP_ACK, 8'h00);
        pkt = '{SLP_CMD_RESET};
        expRun.push_back({1'b1, addr});
        send(1'b0, SLP_ACK, 8'h00);
        check("leftover", expFl.size() + expRun.size(), 0);
        stop_test();
    end
endmodule
